// *** hdl/nco_preset_register_bank.sv ***
// Preset storage for the numeric oscillators, with the phase accumulators it feeds.
// Assumes a classic Wishbone master on mclk_i and inputs synchronous to mclk_i.
module nco_preset_register_bank #(
  parameter int ADDR_W = 12
) (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic sample_en_i,
  input wire logic resync_i,
  input wire logic dual_edge_mode_i,
  input wire logic [1:0] preset_sel_i,
  input wire logic [31:0] chan_a_freq_preset0_i,
  input wire logic [15:0] chan_b_phase_preset0_i,
  output logic [31:0] chan_a_phase_o,
  output logic [31:0] chan_b_phase_o
);

  // Elaboration check on the address width
  if (ADDR_W < nco_preset_pkg::MIN_ADDR_W) begin : g_bad_addr_w
    $error("ADDR_W too narrow for the register map");
  end

  // Address match against a register offset
  function automatic logic addr_hit(input logic [ADDR_W-1:0] adr, input logic [11:0] off);
    addr_hit = (adr == ADDR_W'(off));
  endfunction : addr_hit

  // Byte-lane merge of write data into an old value
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] sel);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < nco_preset_pkg::SEL_W; b++) begin
      if (sel[b]) begin
        res[b*nco_preset_pkg::BYTE_W +: nco_preset_pkg::BYTE_W] =
          new_v[b*nco_preset_pkg::BYTE_W +: nco_preset_pkg::BYTE_W];
      end
    end
    lane_merge = res;
  endfunction : lane_merge

  // Storage
  logic [31:0] freq_ff [nco_preset_pkg::NUM_FREQ_REGS];
  logic [15:0] phase_ff [nco_preset_pkg::NUM_PHASE_REGS];
  logic ack_ff;
  logic [31:0] rdata_ff;
  logic [31:0] acc_a_ff;
  logic [31:0] acc_b_ff;
  logic [31:0] out_a_ff;
  logic [31:0] out_b_ff;

  // Bus request qualification
  wire bus_req = wb_cyc_i && wb_stb_i && !ack_ff;
  wire bus_wr = bus_req && wb_we_i;

  // Per-register hit vectors
  logic [nco_preset_pkg::NUM_FREQ_REGS-1:0] freq_hit;
  logic [nco_preset_pkg::NUM_PHASE_REGS-1:0] phase_hit;
  logic [31:0] freq_rd [nco_preset_pkg::NUM_FREQ_REGS];
  logic [31:0] phase_rd [nco_preset_pkg::NUM_PHASE_REGS];

  // Frequency words: A1, A2, A3, B0, all with the same reset value
  for (genvar i = 0; i < nco_preset_pkg::NUM_FREQ_REGS; i++) begin : g_freq
    assign freq_hit[i] = addr_hit(wb_adr_i, nco_preset_pkg::FREQ_OFFSETS[i]);
    assign freq_rd[i] = freq_hit[i] ? freq_ff[i] : nco_preset_pkg::UNMAPPED_READ;
    wire [31:0] nxt_freq = lane_merge(freq_ff[i], wb_dat_i, wb_sel_i);
    // Register write
    always_ff @(posedge mclk_i) begin
      if (srst_i) begin
        freq_ff[i] <= nco_preset_pkg::FREQ_RESET;
      end else if (bus_wr && freq_hit[i]) begin
        freq_ff[i] <= nxt_freq;
      end
    end
  end

  // Phase words: A0 to A3, 16 bits in the low lanes
  for (genvar i = 0; i < nco_preset_pkg::NUM_PHASE_REGS; i++) begin : g_phase
    assign phase_hit[i] = addr_hit(wb_adr_i, nco_preset_pkg::PHASE_OFFSETS[i]);
    assign phase_rd[i] = phase_hit[i] ? {16'h0000, phase_ff[i]} : nco_preset_pkg::UNMAPPED_READ;
    wire [31:0] nxt_phase = lane_merge({16'h0000, phase_ff[i]}, wb_dat_i, wb_sel_i);
    // Register write
    always_ff @(posedge mclk_i) begin
      if (srst_i) begin
        phase_ff[i] <= nco_preset_pkg::PHASE_RESET;
      end else if (bus_wr && phase_hit[i]) begin
        phase_ff[i] <= nxt_phase[nco_preset_pkg::PHASE_W-1:0];
      end
    end
  end

  // Read mux: OR of one-hot selected words, zero when unmapped
  logic [31:0] nxt_rdata;
  always_comb begin
    nxt_rdata = nco_preset_pkg::UNMAPPED_READ;
    for (int i = 0; i < nco_preset_pkg::NUM_FREQ_REGS; i++) begin
      nxt_rdata = nxt_rdata | freq_rd[i];
    end
    for (int i = 0; i < nco_preset_pkg::NUM_PHASE_REGS; i++) begin
      nxt_rdata = nxt_rdata | phase_rd[i];
    end
  end

  // Bus answer: ack one cycle after the request, dropped the cycle after
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      ack_ff <= 1'b0;
      rdata_ff <= nco_preset_pkg::UNMAPPED_READ;
    end else begin
      ack_ff <= bus_req;
      if (bus_req && !wb_we_i) begin
        rdata_ff <= nxt_rdata;
      end
    end
  end

  // Active preset selection for channel A; preset 0 frequency comes from outside
  wire [31:0] sel_freq_a = (preset_sel_i == 2'h0) ? chan_a_freq_preset0_i : freq_ff[preset_sel_i - 2'h1];
  wire [15:0] sel_phase_a = phase_ff[preset_sel_i];

  // Channel B uses its own words unless in dual-edge mode
  wire [31:0] sel_freq_b = dual_edge_mode_i ? sel_freq_a : freq_ff[nco_preset_pkg::FREQ_IDX_CHAN_B0];
  wire [15:0] sel_phase_b = dual_edge_mode_i ? sel_phase_a : chan_b_phase_preset0_i;

  // Left-justified phase offsets, lower half zero
  wire [31:0] offs_a = {sel_phase_a, {nco_preset_pkg::PHASE_LSB_POS{1'b0}}};
  wire [31:0] offs_b = {sel_phase_b, {nco_preset_pkg::PHASE_LSB_POS{1'b0}}};

  // Modulo two to the 32 sums; sign of the code does not matter
  wire [31:0] nxt_acc_a = acc_a_ff + sel_freq_a;
  wire [31:0] nxt_acc_b = dual_edge_mode_i ? nxt_acc_a : acc_b_ff + sel_freq_b;
  wire [31:0] nxt_out_a = acc_a_ff + offs_a;
  wire [31:0] nxt_out_b = dual_edge_mode_i ? nxt_out_a : acc_b_ff + offs_b;

  // Phase accumulators; resync restarts both for a known phase after retuning
  always_ff @(posedge mclk_i) begin
    if (srst_i || resync_i) begin
      acc_a_ff <= nco_preset_pkg::ACC_RESET;
      acc_b_ff <= nco_preset_pkg::ACC_RESET;
    end else if (sample_en_i) begin
      acc_a_ff <= nxt_acc_a;
      acc_b_ff <= nxt_acc_b;
    end
  end

  // Registered oscillator phase outputs
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      out_a_ff <= nco_preset_pkg::ACC_RESET;
      out_b_ff <= nco_preset_pkg::ACC_RESET;
    end else begin
      out_a_ff <= nxt_out_a;
      out_b_ff <= nxt_out_b;
    end
  end

  // Output drive
  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdata_ff;
  assign chan_a_phase_o = out_a_ff;
  assign chan_b_phase_o = out_b_ff;

  // Checks
  default clocking cb @(posedge mclk_i); endclocking

  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence

  sequence s_phase0_read;
    s_req ##0 (!wb_we_i && addr_hit(wb_adr_i, nco_preset_pkg::OFF_CHAN_A_PHASE_PRESET0));
  endsequence

  a_ack_after_req: assert property (disable iff (srst_i) s_req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single pulse after request");

  a_freq_reset_val: assert property (srst_i |=> freq_ff[0] == nco_preset_pkg::FREQ_RESET
    && freq_ff[1] == nco_preset_pkg::FREQ_RESET
    && freq_ff[2] == nco_preset_pkg::FREQ_RESET)
    else $error("channel A frequency reset value wrong");

  a_chan_b_reset: assert property (srst_i |=> freq_ff[nco_preset_pkg::FREQ_IDX_CHAN_B0] == nco_preset_pkg::FREQ_RESET)
    else $error("channel B frequency reset value wrong");

  a_phase_reset_val: assert property (srst_i |=> phase_ff[0] == 16'h0 && phase_ff[3] == 16'h0)
    else $error("phase reset value wrong");

  a_phase_read_upper: assert property (disable iff (srst_i)
    s_phase0_read |=> wb_ack_o && wb_dat_o[31:16] == 16'h0 && wb_dat_o[15:0] == phase_ff[0])
    else $error("phase read data wrong");

  a_freq_write_a2: assert property (disable iff (srst_i)
    (s_req ##0 (wb_we_i && wb_sel_i == 4'hf && addr_hit(wb_adr_i, nco_preset_pkg::OFF_CHAN_A_FREQ_PRESET2)))
    |=> freq_ff[1] == $past(wb_dat_i))
    else $error("frequency preset 2 write lost");

  a_phase_left_just: assert property (disable iff (srst_i) !srst_i ##1 1'b1
    |-> chan_a_phase_o == $past(acc_a_ff) + {$past(sel_phase_a), 16'h0000})
    else $error("channel A phase offset not left justified");

  a_acc_modulo_step: assert property (disable iff (srst_i)
    (sample_en_i && !resync_i) |=> acc_a_ff == $past(acc_a_ff) + $past(sel_freq_a))
    else $error("accumulator step wrong");

  a_dual_edge_mirror: assert property (disable iff (srst_i) dual_edge_mode_i |=> chan_b_phase_o == chan_a_phase_o)
    else $error("channel B not following channel A in dual-edge mode");

  a_resync_clears: assert property (disable iff (srst_i) resync_i |=> acc_a_ff == 32'h0 && acc_b_ff == 32'h0)
    else $error("resync did not restart accumulators");

  // Full-word write request, used by the B0 frequency and A3 phase write checks
  sequence s_full_write;
    s_req ##0 (wb_we_i && wb_sel_i == 4'hf);
  endsequence

  // Bus handshake and read data hold
  a_bus_reset: assert property (
    srst_i
    |=> !wb_ack_o && wb_dat_o == nco_preset_pkg::UNMAPPED_READ)
    else $error("bus outputs not cleared by reset");

  a_ack_needs_req: assert property (disable iff (srst_i)
    !(wb_cyc_i && wb_stb_i && !wb_ack_o)
    |=> !wb_ack_o)
    else $error("ack without a request");

  a_ack_one_cycle: assert property (disable iff (srst_i)
    wb_ack_o
    |=> !wb_ack_o)
    else $error("ack stood longer than one cycle");

  a_rdata_holds: assert property (disable iff (srst_i)
    !(wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i)
    |=> $stable(wb_dat_o))
    else $error("read data changed without a read");

  a_unmapped_read_zero: assert property (disable iff (srst_i)
    (s_req ##0 (!wb_we_i && !(|freq_hit) && !(|phase_hit)))
    |=> wb_dat_o == nco_preset_pkg::UNMAPPED_READ)
    else $error("unmapped read not zero");

  // Register writes land only where addressed and only in enabled lanes
  a_unmapped_wr_ignored: assert property (disable iff (srst_i)
    (s_req ##0 (wb_we_i && !(|freq_hit) && !(|phase_hit)))
    |=> $stable(freq_ff[0]) && $stable(freq_ff[3]) && $stable(phase_ff[0]) && $stable(phase_ff[3]))
    else $error("unmapped write changed a register");

  a_read_no_write: assert property (disable iff (srst_i)
    (s_req ##0 !wb_we_i)
    |=> $stable(freq_ff[1]) && $stable(phase_ff[1]))
    else $error("read changed a register");

  a_phase_upper_ignored: assert property (disable iff (srst_i)
    (s_req ##0 (wb_we_i && wb_sel_i[1:0] == 2'b00 && addr_hit(wb_adr_i, nco_preset_pkg::OFF_CHAN_A_PHASE_PRESET1)))
    |=> $stable(phase_ff[1]))
    else $error("upper-lane write changed a phase word");

  a_freq_lane_keep: assert property (disable iff (srst_i)
    (s_req ##0 (wb_we_i && !wb_sel_i[3] && addr_hit(wb_adr_i, nco_preset_pkg::OFF_CHAN_A_FREQ_PRESET1)))
    |=> freq_ff[0][31:24] == $past(freq_ff[0][31:24]))
    else $error("disabled byte lane was written");

  a_phase_lane_low: assert property (disable iff (srst_i)
    (s_req ##0 (wb_we_i && wb_sel_i[0] && addr_hit(wb_adr_i, nco_preset_pkg::OFF_CHAN_A_PHASE_PRESET0)))
    |=> phase_ff[0][7:0] == $past(wb_dat_i[7:0]))
    else $error("phase preset 0 low byte write lost");

  a_freq_write_b0: assert property (disable iff (srst_i)
    (s_full_write ##0 addr_hit(wb_adr_i, nco_preset_pkg::OFF_CHAN_B_FREQ_PRESET0))
    |=> freq_ff[nco_preset_pkg::FREQ_IDX_CHAN_B0] == $past(wb_dat_i))
    else $error("channel B frequency write lost");

  a_phase_write_a3: assert property (disable iff (srst_i)
    (s_full_write ##0 addr_hit(wb_adr_i, nco_preset_pkg::OFF_CHAN_A_PHASE_PRESET3))
    |=> phase_ff[3] == $past(wb_dat_i[15:0]))
    else $error("phase preset 3 write lost");

  // Accumulator steps by the frequency word of the chosen preset
  a_step_preset0: assert property (disable iff (srst_i)
    (sample_en_i && !resync_i && preset_sel_i == 2'h0)
    |=> acc_a_ff == $past(acc_a_ff) + $past(chan_a_freq_preset0_i))
    else $error("preset 0 step wrong");

  a_step_preset1: assert property (disable iff (srst_i)
    (sample_en_i && !resync_i && preset_sel_i == 2'h1)
    |=> acc_a_ff == $past(acc_a_ff) + $past(freq_ff[0]))
    else $error("preset 1 step wrong");

  a_step_preset2: assert property (disable iff (srst_i)
    (sample_en_i && !resync_i && preset_sel_i == 2'h2)
    |=> acc_a_ff == $past(acc_a_ff) + $past(freq_ff[1]))
    else $error("preset 2 step wrong");

  a_step_preset3: assert property (disable iff (srst_i)
    (sample_en_i && !resync_i && preset_sel_i == 2'h3)
    |=> acc_a_ff == $past(acc_a_ff) + $past(freq_ff[2]))
    else $error("preset 3 step wrong");

  a_acc_hold: assert property (disable iff (srst_i)
    (!sample_en_i && !resync_i)
    |=> $stable(acc_a_ff) && $stable(acc_b_ff))
    else $error("accumulator moved without a sample");

  a_acc_b_step: assert property (disable iff (srst_i)
    (sample_en_i && !resync_i && !dual_edge_mode_i)
    |=> acc_b_ff == $past(acc_b_ff) + $past(freq_ff[nco_preset_pkg::FREQ_IDX_CHAN_B0]))
    else $error("channel B step wrong");

  a_acc_b_mirror: assert property (disable iff (srst_i)
    (sample_en_i && !resync_i && dual_edge_mode_i)
    |=> acc_b_ff == acc_a_ff)
    else $error("channel B accumulator not following channel A");

  // Channel A phase output carries the left-justified phase word of the chosen preset; channel B uses chan_b_phase_preset0_i outside dual-edge mode
  a_out_reset: assert property (
    srst_i
    |=> chan_a_phase_o == nco_preset_pkg::ACC_RESET && chan_b_phase_o == nco_preset_pkg::ACC_RESET)
    else $error("phase outputs not cleared by reset");

  a_out_a_preset0: assert property (disable iff (srst_i)
    preset_sel_i == 2'h0
    |=> chan_a_phase_o == $past(acc_a_ff) + {$past(phase_ff[0]), 16'h0000})
    else $error("channel A preset 0 phase wrong");

  a_out_a_preset3: assert property (disable iff (srst_i)
    preset_sel_i == 2'h3
    |=> chan_a_phase_o == $past(acc_a_ff) + {$past(phase_ff[3]), 16'h0000})
    else $error("channel A preset 3 phase wrong");

  a_out_b_sum: assert property (disable iff (srst_i)
    !dual_edge_mode_i
    |=> chan_b_phase_o == $past(acc_b_ff) + {$past(chan_b_phase_preset0_i), 16'h0000})
    else $error("channel B phase wrong");

endmodule : nco_preset_register_bank

// *** hdl/nco_preset_pkg.sv ***
// Constants for the numeric oscillator preset register bank.
// Assumes a 32-bit classic Wishbone register bus with byte addresses.
package nco_preset_pkg;

  // Bus and word widths
  localparam int DATA_W = 32;
  localparam int SEL_W = 4;
  localparam int BYTE_W = 8;
  localparam int PHASE_W = 16;
  localparam int PHASE_LSB_POS = 16;
  localparam int MIN_ADDR_W = 10;

  // Preset counts
  localparam int NUM_FREQ_REGS = 4;
  localparam int NUM_PHASE_REGS = 4;
  localparam int PRESET_SEL_W = 2;

  // Register byte offsets
  localparam logic [11:0] OFF_CHAN_A_PHASE_PRESET0 = 12'h224;
  localparam logic [11:0] OFF_CHAN_A_FREQ_PRESET1 = 12'h228;
  localparam logic [11:0] OFF_CHAN_A_PHASE_PRESET1 = 12'h22c;
  localparam logic [11:0] OFF_CHAN_A_FREQ_PRESET2 = 12'h230;
  localparam logic [11:0] OFF_CHAN_A_PHASE_PRESET2 = 12'h234;
  localparam logic [11:0] OFF_CHAN_A_FREQ_PRESET3 = 12'h238;
  localparam logic [11:0] OFF_CHAN_A_PHASE_PRESET3 = 12'h23c;
  localparam logic [11:0] OFF_CHAN_B_FREQ_PRESET0 = 12'h240;

  // Offset tables, index order of the storage arrays
  localparam logic [11:0] FREQ_OFFSETS [NUM_FREQ_REGS] = '{
    OFF_CHAN_A_FREQ_PRESET1, OFF_CHAN_A_FREQ_PRESET2, OFF_CHAN_A_FREQ_PRESET3, OFF_CHAN_B_FREQ_PRESET0};
  localparam logic [11:0] PHASE_OFFSETS [NUM_PHASE_REGS] = '{
    OFF_CHAN_A_PHASE_PRESET0, OFF_CHAN_A_PHASE_PRESET1, OFF_CHAN_A_PHASE_PRESET2, OFF_CHAN_A_PHASE_PRESET3};

  // Index of channel B preset 0 inside the frequency array
  localparam int FREQ_IDX_CHAN_B0 = 3;

  // Reset values
  localparam logic [31:0] FREQ_RESET = 32'hc0000000;
  localparam logic [15:0] PHASE_RESET = 16'h0000;
  localparam logic [31:0] ACC_RESET = 32'h00000000;
  localparam logic [31:0] UNMAPPED_READ = 32'h00000000;

endpackage : nco_preset_pkg

// *** tb/tb.sv ***
// Self-checking bench for the oscillator preset register bank.
// Assumes the bank answers classic Wishbone cycles and steps its accumulators on sample_en_i.
module tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic mclk_i, srst_i, wb_cyc_i, wb_stb_i, wb_we_i;
  logic [11:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic wb_ack_o, sample_en_i, resync_i, dual_edge_mode_i;
  logic [1:0] preset_sel_i;
  logic [31:0] chan_a_freq_preset0_i, chan_a_phase_o, chan_b_phase_o;
  logic [15:0] chan_b_phase_preset0_i;
  logic [31:0] rd, wd;
  int miscompares = 0;
  int cmp_count = 0;
  int cycles = 0;

  nco_preset_register_bank #(.ADDR_W(12)) u_nco_preset_register_bank (
    .mclk_i(mclk_i), .srst_i(srst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .sample_en_i(sample_en_i), .resync_i(resync_i), .dual_edge_mode_i(dual_edge_mode_i),
    .preset_sel_i(preset_sel_i), .chan_a_freq_preset0_i(chan_a_freq_preset0_i),
    .chan_b_phase_preset0_i(chan_b_phase_preset0_i), .chan_a_phase_o(chan_a_phase_o),
    .chan_b_phase_o(chan_b_phase_o));

  // 200 MHz clock
  initial begin
    mclk_i = 1'b0;
    forever #2.5 mclk_i = ~mclk_i;
  end

  task automatic stop_test();
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : stop_test

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk32

  // One classic cycle; request held until ack is sampled high
  task automatic wb_rw(input logic we, input logic [11:0] a, input logic [3:0] s, input logic [31:0] d,
                       output logic [31:0] q);
    int n = 0;
    @(posedge mclk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= d;
    do begin
      @(posedge mclk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    if (n >= 50) begin
      miscompares++;
      stop_test();
    end
  endtask : wb_rw

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    wb_rw(1'b1, a, 4'hf, d, rd);
  endtask : wr

  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    wb_rw(1'b0, a, 4'hf, 32'h0, rd);
    chk32(rd, e);
  endtask : rdc

  // Clear accumulators, step a given number of samples, let outputs settle
  task automatic osc(input logic [1:0] ps, input int steps, input logic de);
    @(posedge mclk_i);
    preset_sel_i <= ps;
    dual_edge_mode_i <= de;
    resync_i <= 1'b1;
    @(posedge mclk_i);
    resync_i <= 1'b0;
    sample_en_i <= 1'b1;
    repeat (steps) @(posedge mclk_i);
    sample_en_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
  endtask : osc

  // Hang guard
  always @(posedge mclk_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      miscompares++;
      stop_test();
    end
  end

  // Main sequence
  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i, sample_en_i, resync_i, dual_edge_mode_i} = 6'h00;
    wb_adr_i = 12'h000;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    preset_sel_i = 2'h0;
    chan_a_freq_preset0_i = 32'h00001000;
    chan_b_phase_preset0_i = 16'h0004;
    srst_i = 1'b1;
    repeat (20) @(posedge mclk_i);
    srst_i <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      rdc(12'h224 + 12'(i * 4), i[0] ? 32'hc0000000 : 32'h0);
    end
    for (int i = 0; i < 8; i++) begin
      wd = 32'h13579bdf ^ (i * 32'h11111111);
      wr(12'h224 + 12'(i * 4), wd);
      rdc(12'h224 + 12'(i * 4), wd & (i[0] ? 32'hffffffff : 32'h0000ffff));
    end
    wb_rw(1'b1, 12'h228, 4'b0010, 32'hffffabff, rd);
    rdc(12'h228, 32'h0246abce);
    wb_rw(1'b1, 12'h22c, 4'hc, 32'hffffffff, rd);
    rdc(12'h22c, 32'h0000b9fd);
    wr(12'h220, 32'hffffffff);
    rdc(12'h220, 32'h0);
    rdc(12'h244, 32'h0);
    rdc(12'h240, 32'h13579bdf ^ (7 * 32'h11111111));
    wr(12'h228, 32'h01000000);
    wr(12'h22c, 32'h00008000);
    wr(12'h230, 32'h40000000);
    wr(12'h234, 32'h0000ffff);
    wr(12'h224, 32'h00000001);
    wr(12'h240, 32'h00100000);
    wr(12'h238, 32'h00000010);
    wr(12'h23c, 32'h00001234);
    osc(2'd1, 3, 1'b0);
    chk32(chan_a_phase_o, 32'h83000000);
    osc(2'd2, 5, 1'b0);
    chk32(chan_a_phase_o, 32'h3fff0000);
    osc(2'd0, 2, 1'b0);
    chk32(chan_a_phase_o, 32'h00012000);
    chk32(chan_b_phase_o, 32'h00240000);
    osc(2'd3, 1, 1'b1);
    chk32(chan_a_phase_o, 32'h12340010);
    chk32(chan_b_phase_o, 32'h12340010);
    stop_test();
  end
endmodule : tb
